/* rtl/rcg_map.svh */
/*
 * constants of the run command generator: function codes, bit positions,
 * property selections and reset values.
 * assumes it is included by the design file and the checker only.
 */
//
// Contract
// R1: outside jogging, keypad run key latches run request until stop key pressed
// R2: while hold_latch on, run_forward and backward_run_cmd stay latched
// R3: with no terminal assigned hold_latch, direction levels act directly
// R4: source 0: run only with keypad request and matching direction command
// R5: link word bit 0 forward, bit 1 reverse, bits 13/14 programmable
// R6: terminal property settings select which link bit drives each run
// R7: bits 13 and 14 with same function pass through a merging stage
// R8: merging stage ORs both bits; unassigned partner passes other through
// R9: network_control_on high whenever link bit 13 or 14 is one
// R10: forward and reverse both on forces both internal runs off
// R11: stop priority 1 or 3: stop key forces both runs off
// R12: timer starts on run; expiry clears run and keypad hold
// R13: runs held off while set frequency below start or stop frequency
// R14: terminal function setting picks command; plus 1000 inverts input
// R15: general commands take link value when link operation selected
// R16: terminal-dedicated commands come only from the terminal block
// R17: forward and reverse decoder ignores link settings
// R18: forward and reverse inputs always positive logic
// R19: OR-group commands on when link bit or terminal is on
// R20: ignore-link commands use terminal only, even with link on
// R21: internal run commands are registered on the control clock
`ifndef RCG_MAP_SVH
`define RCG_MAP_SVH

// ****************************************************************
// function codes of input terminals
// ****************************************************************
`define RCG_FN_NEG_OFS   16'd1000
`define RCG_FN_HOLD      16'd6
`define RCG_FN_LINK_ON   16'd24
`define RCG_FN_FWD       16'd98
`define RCG_FN_REV       16'd99
`define RCG_FN_GEN_A     16'd10
`define RCG_FN_TERM_A    16'd11
`define RCG_FN_OR_A      16'd12
`define RCG_FN_IGN_A     16'd13

// ****************************************************************
// link word bits
// ****************************************************************
`define RCG_LW_FWD       0
`define RCG_LW_REV       1
`define RCG_LW_PRG_A     13
`define RCG_LW_PRG_B     14
`define RCG_LW_GEN_A     2
`define RCG_LW_OR_A      3

// ****************************************************************
// settings and reset values
// ****************************************************************
`define RCG_SRC_KEYPAD   2'h0
`define RCG_SRC_TERM     2'h1
`define RCG_STOP_PRI_A   2'h1
`define RCG_STOP_PRI_B   2'h3
`define RCG_TIMER_RST    32'h0000_0000

`endif

/* rtl/rcg_pkg.sv */
/*
 * types of the run command generator.
 * assumes rcg_map.svh constants are available beside it.
 */
package rcg_pkg;

    typedef enum logic [1:0] {
        RCG_RUN_IDLE  = 2'b00,
        RCG_RUN_ON    = 2'b01,
        RCG_RUN_TIMED = 2'b10
    } rcg_timer_st_t;

endpackage

/* rtl/rcg_run_cmd_gen.sv */
/*
 * run command generator: decodes terminals, keypad keys and the link
 * operation word into registered forward and reverse run commands.
 * assumes all inputs synchronous to SYS_CLK and settings held stable.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rcg_map.svh"

module rcg_run_cmd_gen
    import rcg_pkg::*;
(
    input  wire logic        SYS_CLK,          // control clock
    input  wire logic        RST_B,            // sync reset, active low
    input  wire logic        TERM_FWD,         // forward terminal level
    input  wire logic        TERM_REV,         // reverse terminal level
    input  wire logic [2:0]  TERM_X,           // terminals one to three
    input  wire logic [15:0] FN_X1,            // input_terminal_one function
    input  wire logic [15:0] FN_X2,            // input_terminal_two function
    input  wire logic [15:0] FN_X3,            // input_terminal_three func
    input  wire logic [15:0] FWD_PROP,         // forward_terminal_property
    input  wire logic [15:0] BWD_PROP,         // backward_terminal_property
    input  wire logic [15:0] LINK_WORD,        // link_operation_word
    input  wire logic        LINK_SEL,         // link operation selected
    input  wire logic [1:0]  RUN_SRC,          // run_source_select
    input  wire logic [1:0]  STOP_PRI,         // stop_priority_setting
    input  wire logic        KEY_RUN,          // keypad run key pressed
    input  wire logic        KEY_STOP,         // keypad stop key pressed
    input  wire logic        JOG_ACTIVE,       // jogging in progress
    input  wire logic        TIMER_EN,         // timer operation enabled
    input  wire logic [31:0] TIMER_PRESET,     // timer length in clocks
    input  wire logic [15:0] SET_FREQ,         // set frequency
    input  wire logic [15:0] START_FREQ,       // start_frequency
    input  wire logic [15:0] STOP_FREQ,        // stop_frequency
    output logic             RUN_FWD,          // internal forward run
    output logic             RUN_REV,          // internal reverse run
    output logic             NET_CTRL_ON,      // network_control_on
    output logic             HOLD_ON,          // hold_latch command
    output logic             GEN_CMD,          // general-group command
    output logic             TERM_CMD,         // terminal-dedicated command
    output logic             OR_CMD,           // OR-group command
    output logic             IGN_CMD           // ignore-link-group command
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // level of a terminal for a function code, negative logic by +1000
    function automatic logic term_hit(input logic [15:0] fn,
                                      input logic [15:0] code,
                                      input logic        lvl);
        if (fn == code)
            return lvl;
        else if (fn == code + `RCG_FN_NEG_OFS)
            return ~lvl;
        else
            return 1'b0;
    endfunction

    function automatic logic assigned(input logic [15:0] fn,
                                      input logic [15:0] code);
        return (fn == code) || (fn == code + `RCG_FN_NEG_OFS);
    endfunction

    function automatic logic any_term(input logic [15:0] code,
                                      input logic [2:0]  lvl,
                                      input logic [15:0] f1,
                                      input logic [15:0] f2,
                                      input logic [15:0] f3);
        return term_hit(f1, code, lvl[0]) | term_hit(f2, code, lvl[1])
             | term_hit(f3, code, lvl[2]);
    endfunction

    // ****************************************************************
    // terminal command decoders
    // ****************************************************************
    logic hold_assigned;
    logic hold_term;
    logic link_on_term;
    logic gen_term;
    logic or_term;

    assign hold_assigned = assigned(FN_X1, `RCG_FN_HOLD)
                         | assigned(FN_X2, `RCG_FN_HOLD)
                         | assigned(FN_X3, `RCG_FN_HOLD);
    assign hold_term     = any_term(`RCG_FN_HOLD, TERM_X,
                                    FN_X1, FN_X2, FN_X3);      // R14
    assign link_on_term  = any_term(`RCG_FN_LINK_ON, TERM_X,
                                    FN_X1, FN_X2, FN_X3);
    assign gen_term      = any_term(`RCG_FN_GEN_A, TERM_X,
                                    FN_X1, FN_X2, FN_X3);
    assign or_term       = any_term(`RCG_FN_OR_A, TERM_X,
                                    FN_X1, FN_X2, FN_X3);

    // link bits 13/14 with property selection and merging
    logic lw13;
    logic lw14;
    logic link_fwd;
    logic link_rev;
    logic link_sel_eff;

    assign lw13 = LINK_WORD[`RCG_LW_PRG_A];                     // R5
    assign lw14 = LINK_WORD[`RCG_LW_PRG_B];                     // R5
    assign NET_CTRL_ON = lw13 | lw14;                           // R9
    assign link_sel_eff = LINK_SEL | link_on_term | NET_CTRL_ON;

    // property of each programmable bit: fwd prop ties to bit 13,
    // bwd prop to bit 14; same code merges both onto one command
    logic b13_fwd;
    logic b14_fwd;
    logic b13_rev;
    logic b14_rev;

    assign b13_fwd = (FWD_PROP == `RCG_FN_FWD);                 // R6
    assign b14_fwd = (BWD_PROP == `RCG_FN_FWD);                 // R6
    assign b13_rev = (FWD_PROP == `RCG_FN_REV);                 // R6
    assign b14_rev = (BWD_PROP == `RCG_FN_REV);                 // R6

    // merged output is OR; an unassigned bit contributes nothing
    assign link_fwd = LINK_WORD[`RCG_LW_FWD]
                    | (b13_fwd & lw13) | (b14_fwd & lw14);      // R7 R8
    assign link_rev = LINK_WORD[`RCG_LW_REV]
                    | (b13_rev & lw13) | (b14_rev & lw14);      // R7 R8

    // forward and reverse terminals: positive logic, no link here
    logic dir_fwd;
    logic dir_rev;

    assign dir_fwd = TERM_FWD;                                  // R17 R18
    assign dir_rev = TERM_REV;                                  // R17 R18

    // ****************************************************************
    // grouped command outputs
    // ****************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            GEN_CMD  <= 1'b0;
            TERM_CMD <= 1'b0;
            OR_CMD   <= 1'b0;
            IGN_CMD  <= 1'b0;
        end else begin
            GEN_CMD  <= LINK_SEL ? LINK_WORD[`RCG_LW_GEN_A]
                                 : gen_term;                    // R15
            TERM_CMD <= any_term(`RCG_FN_TERM_A, TERM_X,
                                 FN_X1, FN_X2, FN_X3);          // R16
            OR_CMD   <= or_term | LINK_WORD[`RCG_LW_OR_A];      // R19
            IGN_CMD  <= any_term(`RCG_FN_IGN_A, TERM_X,
                                 FN_X1, FN_X2, FN_X3);          // R20
        end
    end

    // ****************************************************************
    // keypad run request latch
    // ****************************************************************
    logic key_req_q;
    logic timer_done;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B)
            key_req_q <= 1'b0;
        else if (KEY_STOP || timer_done)
            key_req_q <= 1'b0;                                  // R1 R12
        else if (KEY_RUN && !JOG_ACTIVE)
            key_req_q <= 1'b1;                                  // R1
    end

    // ****************************************************************
    // direction selection and three-wire hold
    // ****************************************************************
    logic sel_fwd;
    logic sel_rev;
    logic hold_fwd_q;
    logic hold_rev_q;
    logic cmd_fwd;
    logic cmd_rev;

    assign sel_fwd = link_sel_eff ? link_fwd : dir_fwd;
    assign sel_rev = link_sel_eff ? link_rev : dir_rev;
    assign HOLD_ON = hold_term;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            hold_fwd_q <= 1'b0;
            hold_rev_q <= 1'b0;
        end else if (!hold_term || timer_done) begin
            hold_fwd_q <= 1'b0;                                 // R2 R12
            hold_rev_q <= 1'b0;
        end else begin
            hold_fwd_q <= hold_fwd_q | sel_fwd;                 // R2
            hold_rev_q <= hold_rev_q | sel_rev;                 // R2
        end
    end

    assign cmd_fwd = hold_assigned ? (sel_fwd | hold_fwd_q) : sel_fwd; // R3
    assign cmd_rev = hold_assigned ? (sel_rev | hold_rev_q) : sel_rev; // R3

    // ****************************************************************
    // run source and overrides
    // ****************************************************************
    logic run_fwd_d;
    logic run_rev_d;
    logic any_run;
    logic stop_force;
    logic freq_low;

    assign stop_force = KEY_STOP && (STOP_PRI == `RCG_STOP_PRI_A
                                  || STOP_PRI == `RCG_STOP_PRI_B); // R11
    assign freq_low   = (SET_FREQ < START_FREQ)
                     || (SET_FREQ < STOP_FREQ);                 // R13

    always_comb begin
        if (RUN_SRC == `RCG_SRC_KEYPAD) begin
            run_fwd_d = key_req_q & cmd_fwd;                    // R4
            run_rev_d = key_req_q & cmd_rev;                    // R4
        end else begin
            run_fwd_d = cmd_fwd;
            run_rev_d = cmd_rev;
        end
        if ((cmd_fwd && cmd_rev) || stop_force || freq_low
            || timer_done) begin
            run_fwd_d = 1'b0;                                   // R10 R11 R13
            run_rev_d = 1'b0;
        end
    end

    assign any_run = cmd_fwd | cmd_rev;

    // ****************************************************************
    // run timer
    // ****************************************************************
    rcg_timer_st_t tmr_st_q;
    logic [31:0]   tmr_cnt_q;

    assign timer_done = (tmr_st_q == RCG_RUN_TIMED);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            tmr_st_q  <= RCG_RUN_IDLE;
            tmr_cnt_q <= `RCG_TIMER_RST;
        end else begin
            unique case (tmr_st_q)
                RCG_RUN_IDLE: begin
                    tmr_cnt_q <= `RCG_TIMER_RST;
                    if (TIMER_EN && any_run)
                        tmr_st_q <= RCG_RUN_ON;                 // R12
                end
                RCG_RUN_ON: begin
                    tmr_cnt_q <= tmr_cnt_q + 32'h0000_0001;
                    if (!TIMER_EN)
                        tmr_st_q <= RCG_RUN_IDLE;
                    else if (tmr_cnt_q + 32'h0000_0001 >= TIMER_PRESET)
                        tmr_st_q <= RCG_RUN_TIMED;              // R12
                end
                RCG_RUN_TIMED: begin
                    if (!any_run && !key_req_q)
                        tmr_st_q <= RCG_RUN_IDLE;
                end
                default: tmr_st_q <= RCG_RUN_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // registered run outputs
    // ****************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            RUN_FWD <= 1'b0;
            RUN_REV <= 1'b0;
        end else begin
            RUN_FWD <= run_fwd_d;                               // R21
            RUN_REV <= run_rev_d;                               // R21
        end
    end

endmodule

`default_nettype wire

/* sim/rcg_run_cmd_gen_sva.sv */
/* checker of the run command generator outputs.
   assumes it is bound to rcg_run_cmd_gen and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "rcg_map.svh"
module rcg_run_cmd_gen_sva (
    input wire logic        SYS_CLK,     // clock
    input wire logic        RST_B,       // reset
    input wire logic        TERM_FWD,    // forward level
    input wire logic        TERM_REV,    // reverse level
    input wire logic [2:0]  TERM_X,      // terminals
    input wire logic [15:0] FN_X1,       // function one
    input wire logic [15:0] FN_X2,       // function two
    input wire logic [15:0] FN_X3,       // function three
    input wire logic [15:0] LINK_WORD,   // link word
    input wire logic        LINK_SEL,    // link selected
    input wire logic [1:0]  RUN_SRC,     // run source
    input wire logic [1:0]  STOP_PRI,    // stop priority
    input wire logic        KEY_STOP,    // stop key
    input wire logic        TIMER_EN,    // timer on
    input wire logic [15:0] SET_FREQ,    // set frequency
    input wire logic [15:0] START_FREQ,  // start frequency
    input wire logic [15:0] STOP_FREQ,   // stop frequency
    input wire logic        RUN_FWD,     // forward run
    input wire logic        RUN_REV,     // reverse run
    input wire logic        NET_CTRL_ON, // link flag
    input wire logic        HOLD_ON,     // hold flag
    input wire logic        OR_CMD,      // or-group command
    input wire logic        IGN_CMD      // ignore-link command
);
    // ****************************************************************
    // output relations
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    AST_RST: assert property (disable iff (1'h0)
        !RST_B |=> !RUN_FWD && !RUN_REV && !OR_CMD && !IGN_CMD)
        else $error("outputs not cleared by reset");
    AST_BOTH: assert property (
        TERM_FWD && TERM_REV && !LINK_SEL && !NET_CTRL_ON
        |=> !RUN_FWD && !RUN_REV) else $error("both directions ran");
    AST_STOP: assert property (
        KEY_STOP && STOP_PRI[0] |=> !RUN_FWD && !RUN_REV)
        else $error("stop key did not stop");
    AST_FREQ: assert property (
        SET_FREQ < START_FREQ || SET_FREQ < STOP_FREQ
        |=> !RUN_FWD && !RUN_REV) else $error("run below frequency");
    AST_NET: assert property (
        NET_CTRL_ON == (LINK_WORD[13] || LINK_WORD[14]))
        else $error("link flag wrong");
    AST_FWD: assert property (
        $rose(TERM_FWD) && RUN_SRC != 2'h0 && !TERM_REV && !KEY_STOP
        && !LINK_SEL && !NET_CTRL_ON && !HOLD_ON && !$past(HOLD_ON)
        && !TIMER_EN && SET_FREQ >= START_FREQ && SET_FREQ >= STOP_FREQ
        |=> RUN_FWD) else $error("forward level did not run");
    AST_OR: assert property (
        FN_X1 == `RCG_FN_OR_A && FN_X2 != `RCG_FN_OR_A
        && FN_X3 != `RCG_FN_OR_A
        |=> OR_CMD == ($past(TERM_X[0]) || $past(LINK_WORD[3])))
        else $error("or-group command wrong");
    AST_IGN: assert property (
        FN_X1 == `RCG_FN_IGN_A && FN_X2 != `RCG_FN_IGN_A
        && FN_X3 != `RCG_FN_IGN_A |=> IGN_CMD == $past(TERM_X[0]))
        else $error("ignore-link command wrong");
endmodule
bind rcg_run_cmd_gen rcg_run_cmd_gen_sva u_rcg_run_cmd_gen_sva (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .TERM_FWD(TERM_FWD),
    .TERM_REV(TERM_REV), .TERM_X(TERM_X), .FN_X1(FN_X1), .FN_X2(FN_X2),
    .FN_X3(FN_X3), .LINK_WORD(LINK_WORD), .LINK_SEL(LINK_SEL),
    .RUN_SRC(RUN_SRC), .STOP_PRI(STOP_PRI), .KEY_STOP(KEY_STOP),
    .TIMER_EN(TIMER_EN), .SET_FREQ(SET_FREQ), .START_FREQ(START_FREQ),
    .STOP_FREQ(STOP_FREQ), .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV),
    .NET_CTRL_ON(NET_CTRL_ON), .HOLD_ON(HOLD_ON), .OR_CMD(OR_CMD),
    .IGN_CMD(IGN_CMD));
`default_nettype wire

/* sim/rcg_keypad_model.sv */
/* keypad model: a one-cycle press request becomes a held key.
   assumes requests change at the falling edge of sys_clk. */
`timescale 1ns/1ns
`default_nettype none
module rcg_keypad_model #(parameter int PRESS = 3) (
    input  wire logic sys_clk,  // clock
    input  wire logic run_rq,   // press run key
    input  wire logic stop_rq,  // press stop key
    output var logic  key_run,  // run key level
    output var logic  key_stop  // stop key level
);
    int run_n = 0;
    int stop_n = 0;
    initial {key_run, key_stop} = 2'h0;
    always @(posedge sys_clk) begin
        run_n <= run_rq ? PRESS : (run_n > 0 ? run_n - 1 : 0);
        stop_n <= stop_rq ? PRESS : (stop_n > 0 ? stop_n - 1 : 0);
    end
    // keys move at the falling edge, away from the sampling edge
    always @(negedge sys_clk) begin
        key_run <= run_n > 0;
        key_stop <= stop_n > 0;
    end
endmodule
`default_nettype wire

/* sim/rcg_run_cmd_gen_bench.sv */
/* bench of the run command generator: table of plain cases, then
   keypad, stop key, frequency gate, timer, hold and reset cases.
   assumes the keypad model and the checker are compiled beside it. */
`timescale 1ns/1ns
`default_nettype none
module rcg_run_cmd_gen_bench;
    typedef struct {
        logic [15:0] fn, lw, fp, bp;
        logic [5:0]  lv, ex, care;
    } rcg_row_t;
    logic        sys_clk = 1'h0, rst_b = 1'h0, tf, tr, ls, ten, krq, srq;
    logic        key_run, key_stop, rf, rr, net, hold, gen, term, orc, ign, jog;
    logic [2:0]  tx;
    logic [1:0]  src, pri;
    logic [5:0]  d;
    logic [15:0] f1, fp, bp, lw, sf, stf, spf;
    logic [31:0] pre;
    int          n_mismatch = 0, tests_run = 0, cyc_n = 0, k;
    // lv is {terminals, link select, forward, reverse}
    rcg_row_t    rows[20] = '{
        '{16'ha, 16'h0, 16'h0, 16'h0, 6'h0a, 6'h28, 6'h38},
        '{16'h3f2, 16'h0, 16'h0, 16'h0, 6'h09, 6'h10, 6'h38},
        '{16'h3f2, 16'h0, 16'h0, 16'h0, 6'h03, 6'h08, 6'h38},
        '{16'ha, 16'h0, 16'h0, 16'h0, 6'h0c, 6'h00, 6'h38},
        '{16'ha, 16'h4, 16'h0, 16'h0, 6'h04, 6'h08, 6'h38},
        '{16'hb, 16'h4, 16'h0, 16'h0, 6'h0c, 6'h04, 6'h34},
        '{16'hb, 16'h0, 16'h0, 16'h0, 6'h00, 6'h00, 6'h34},
        '{16'hc, 16'h8, 16'h0, 16'h0, 6'h00, 6'h02, 6'h32},
        '{16'hc, 16'h0, 16'h0, 16'h0, 6'h08, 6'h02, 6'h32},
        '{16'hd, 16'h6000, 16'h0, 16'h0, 6'h04, 6'h00, 6'h31},
        '{16'hd, 16'h2000, 16'h0, 16'h0, 6'h08, 6'h01, 6'h31},
        '{16'h3f5, 16'h0, 16'h0, 16'h0, 6'h00, 6'h01, 6'h31},
        '{16'h0, 16'h2000, 16'h62, 16'h0, 6'h04, 6'h20, 6'h30},
        '{16'h0, 16'h6000, 16'h62, 16'h62, 6'h04, 6'h20, 6'h30},
        '{16'h0, 16'h4000, 16'h0, 16'h62, 6'h04, 6'h20, 6'h30},
        '{16'h0, 16'h6000, 16'h62, 16'h63, 6'h04, 6'h00, 6'h30},
        '{16'h0, 16'h2, 16'h0, 16'h0, 6'h04, 6'h10, 6'h30},
        '{16'h0, 16'h1, 16'h0, 16'h0, 6'h04, 6'h20, 6'h30},
        '{16'h6, 16'h0, 16'h0, 16'h0, 6'h0a, 6'h20, 6'h30},
        '{16'h18, 16'h1, 16'h0, 16'h0, 6'h08, 6'h20, 6'h30}};

    rcg_run_cmd_gen u_rcg_run_cmd_gen (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .TERM_FWD(tf), .TERM_REV(tr),
        .TERM_X(tx), .FN_X1(f1), .FN_X2(16'h0), .FN_X3(16'h0),
        .FWD_PROP(fp), .BWD_PROP(bp), .LINK_WORD(lw), .LINK_SEL(ls),
        .RUN_SRC(src), .STOP_PRI(pri), .KEY_RUN(key_run),
        .KEY_STOP(key_stop), .JOG_ACTIVE(jog), .TIMER_EN(ten),
        .TIMER_PRESET(pre), .SET_FREQ(sf), .START_FREQ(stf),
        .STOP_FREQ(spf), .RUN_FWD(rf), .RUN_REV(rr), .NET_CTRL_ON(net),
        .HOLD_ON(hold), .GEN_CMD(gen), .TERM_CMD(term), .OR_CMD(orc),
        .IGN_CMD(ign));
    rcg_keypad_model u_rcg_keypad_model (.sys_clk(sys_clk), .run_rq(krq),
        .stop_rq(srq), .key_run(key_run), .key_stop(key_stop));

    // ****************************************************************
    // clock, limit and helpers
    // ****************************************************************
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'h1) begin
            $display("MISMATCH %0t %s", $time, m);
            n_mismatch++;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {tr, ls, ten, krq, srq, jog, tx, pri, f1, fp, bp, lw} = '0;
        {sf, stf, spf, pre} = {16'h20, 16'h10, 16'h10, 32'h5};
        src = 2'h1;
        tf = 1'h1;
        cyc(19);
        chk(rf === 1'h0, "run during reset");
        cyc(1);
        rst_b = 1'h1;
        foreach (rows[i]) begin
            {tx, ls, tf, tr} = rows[i].lv;
            {f1, lw} = {rows[i].fn, rows[i].lw};
            {fp, bp} = {rows[i].fp, rows[i].bp};
            cyc(2);
            d = ({rf, rr, gen, term, orc, ign} ^ rows[i].ex) & rows[i].care;
            chk(d === 6'h0, "table");
            chk(net === (lw[13] | lw[14]), "link flag");
            chk(hold === (f1 == 16'h6 && tx[0]), "hold flag");
        end
        {f1, lw, ls, tx, tr, src} = '0;
        tf = 1'h1;
        cyc(3);
        chk(rf === 1'h0, "run without key");
        jog = 1'h1;
        krq = 1'h1;
        cyc(1);
        krq = 1'h0;
        cyc(6);
        chk(rf === 1'h0, "key latched while jogging");
        jog = 1'h0;
        krq = 1'h1;
        cyc(1);
        krq = 1'h0;
        cyc(6);
        chk(rf === 1'h1 && key_run === 1'h0, "key latch");
        {tf, tr} = 2'h1;
        cyc(2);
        chk({rf, rr} === 2'h1, "key direction");
        srq = 1'h1;
        cyc(1);
        srq = 1'h0;
        cyc(6);
        chk(rr === 1'h0, "stop key release");
        src = 2'h1;
        {tf, tr} = 2'h2;
        for (int p = 0; p < 4; p++) begin
            pri = p[1:0];
            cyc(5);
            srq = 1'h1;
            cyc(1);
            srq = 1'h0;
            cyc(1);
            chk(rf === ~pri[0], "stop key priority");
        end
        pri = 2'h0;
        stf = 16'h21;
        cyc(2);
        chk(rf === 1'h0, "below start");
        {stf, spf} = {16'h20, 16'h21};
        cyc(2);
        chk(rf === 1'h0, "below stop");
        spf = 16'h20;
        cyc(2);
        chk(rf === 1'h1, "at start and stop");
        tf = 1'h0;
        ten = 1'h1;
        cyc(2);
        tf = 1'h1;
        k = 0;
        cyc(2);
        while (rf === 1'h1 && k < 20) begin
            k++;
            cyc(1);
        end
        chk(k >= 2 && k <= 7, "timer length");
        cyc(5);
        chk(rf === 1'h0, "timer stays expired");
        {tf, ten} = 2'h0;
        cyc(2);
        tf = 1'h1;
        cyc(2);
        chk(rf === 1'h1, "timer release");
        {f1, tx} = {16'h6, 3'h1};
        cyc(2);
        tf = 1'h0;
        cyc(2);
        chk(rf === 1'h1, "hold keeps run");
        tx = 3'h0;
        cyc(2);
        chk(rf === 1'h0, "hold release");
        tf = 1'h1;
        cyc(2);
        rst_b = 1'h0;
        cyc(1);
        chk(rf === 1'h0, "mid reset");
        rst_b = 1'h1;
        cyc(2);
        chk(rf === 1'h1, "after reset");
        end_of_test;
    end
endmodule
`default_nettype wire
